// ---- pkg/pwb_pkg.sv ----
// Purpose: shared constants and types for the pwm period/width buffering block
// Assumes: axi4-lite register access, 32-bit data, one aligned word per register
// Notes:   offsets chosen locally; reserved bits read as zero
package pwb_pkg;
  localparam int unsigned      DATA_W          = 32;
  localparam int unsigned      ADDR_W          = 8;
  localparam int unsigned      CNT_W           = 16;
  localparam logic [7:0]       OFF_CTRL        = 8'h00;
  localparam logic [7:0]       OFF_PERIOD      = 8'h04;
  localparam logic [7:0]       OFF_WIDTH       = 8'h08;
  localparam logic [7:0]       OFF_COUNT       = 8'h0C;
  localparam logic [7:0]       OFF_IRQ_STATUS  = 8'h10;
  localparam logic [7:0]       OFF_IRQ_ENABLE  = 8'h14;
  localparam logic [7:0]       OFF_IRQ_CLEAR   = 8'h18;
  localparam int unsigned      BIT_CLK_LO      = 0;
  localparam int unsigned      BIT_EN          = 3;
  localparam int unsigned      BIT_POL         = 4;
  localparam int unsigned      BIT_LOAD        = 5;
  localparam int unsigned      BIT_DIV3        = 6;
  localparam int unsigned      BIT_PIN         = 7;
  localparam int unsigned      BIT_IRQ_PERIOD  = 0;
  localparam logic [15:0]      COUNT_RESET     = 16'h0001;
  localparam logic [15:0]      HOLD_RESET      = 16'h0000;
  localparam logic [1:0]       RESP_OKAY       = 2'h0;
  localparam logic [1:0]       RESP_SLVERR     = 2'h2;

  typedef struct packed {
    logic [2:0] rate_sel;
    logic       enable;
    logic       output_polarity;
    logic       prescale_divide_by_three;
  } pwb_ctrl_s;
endpackage

// ---- rtl/pwb_prescaler.sv ----
// Purpose: counter clock enable generator, /2 or /3 first stage then binary chain
// Assumes: single clock, synchronous reset
// Notes:   held cleared while hold is high
`timescale 1ns/10ps
module pwb_prescaler #(
  parameter int unsigned CHAIN_W = 8
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       hold,
  input  wire logic       div3,
  input  wire logic [2:0] rate_sel,
  output logic            tick
);
  logic [1:0]         first_reg;
  logic               first_tick;
  logic [CHAIN_W-1:0] chain_reg;
  logic               sel_hit;

  assign first_tick = div3 ? (first_reg == 2'h2) : (first_reg == 2'h1);

  // first prescaled clock: /2 or /3
  always_ff @(posedge clk) begin
    if (rst || hold) begin
      first_reg <= 2'h0;
    end else if (first_tick) begin
      first_reg <= 2'h0;
    end else begin
      first_reg <= first_reg + 2'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || hold) begin
      chain_reg <= '0;
    end else if (first_tick) begin
      chain_reg <= chain_reg + {{(CHAIN_W-1){1'b0}}, 1'b1};
    end
  end

  // codes 0..6 give 2^code, code 7 gives 256
  always_comb begin
    case (rate_sel)
      3'h0:    sel_hit = 1'b1;
      3'h1:    sel_hit = (chain_reg[0:0] == 1'h1);
      3'h2:    sel_hit = (chain_reg[1:0] == 2'h3);
      3'h3:    sel_hit = (chain_reg[2:0] == 3'h7);
      3'h4:    sel_hit = (chain_reg[3:0] == 4'hF);
      3'h5:    sel_hit = (chain_reg[4:0] == 5'h1F);
      3'h6:    sel_hit = (chain_reg[5:0] == 6'h3F);
      default: sel_hit = (chain_reg == {CHAIN_W{1'b1}});
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst || hold) begin
      tick <= 1'b0;
    end else begin
      tick <= first_tick && sel_hit;
    end
  end
endmodule

// ---- rtl/pwb_axil_slave.sv ----
// Purpose: axi4-lite slave front end presenting simple write/read strobes
// Assumes: one write and one read at a time
// Notes:   write strobe fires when both address and data are held
`timescale 1ns/10ps
module pwb_axil_slave #(
  parameter int unsigned AW = 8
) (
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic [AW-1:0] s_axi_awaddr,
  input  wire logic          s_axi_awvalid,
  output logic               s_axi_awready,
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  input  wire logic          s_axi_wvalid,
  output logic               s_axi_wready,
  output logic [1:0]         s_axi_bresp,
  output logic               s_axi_bvalid,
  input  wire logic          s_axi_bready,
  input  wire logic [AW-1:0] s_axi_araddr,
  input  wire logic          s_axi_arvalid,
  output logic               s_axi_arready,
  output logic [31:0]        s_axi_rdata,
  output logic [1:0]         s_axi_rresp,
  output logic               s_axi_rvalid,
  input  wire logic          s_axi_rready,
  output logic               wr_en,
  output logic [AW-1:0]      wr_addr,
  output logic [31:0]        wr_data,
  output logic [3:0]         wr_strb,
  input  wire logic          wr_err,
  output logic               rd_en,
  output logic [AW-1:0]      rd_addr,
  input  wire logic [31:0]   rd_data,
  input  wire logic          rd_err
);
  logic aw_have;
  logic w_have;

  assign wr_en   = aw_have && w_have && !s_axi_bvalid;
  assign rd_en   = s_axi_arvalid && s_axi_arready;
  assign rd_addr = s_axi_araddr;

  always_ff @(posedge clk) begin
    if (rst) begin
      aw_have       <= 1'b0;
      w_have        <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= pwb_pkg::RESP_OKAY;
      wr_addr       <= '0;
      wr_data       <= '0;
      wr_strb       <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have       <= 1'b1;
        s_axi_awready <= 1'b0;
        wr_addr       <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have       <= 1'b1;
        s_axi_wready <= 1'b0;
        wr_data      <= s_axi_wdata;
        wr_strb      <= s_axi_wstrb;
      end
      if (wr_en) begin
        aw_have      <= 1'b0;
        w_have       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_err ? pwb_pkg::RESP_SLVERR : pwb_pkg::RESP_OKAY;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= pwb_pkg::RESP_OKAY;
    end else if (rd_en) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_data;
      s_axi_rresp   <= rd_err ? pwb_pkg::RESP_SLVERR : pwb_pkg::RESP_OKAY;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
endmodule

// ---- rtl/pwb_pwm.sv ----
// Purpose: pwm submodule with period/width holding and active buffers, counter, prescaler
// Assumes: axi4-lite master, single 125 MHz clock, synchronous active-high reset
// Notes:   active buffers are not bus visible; interrupt on period completion
//
// Design decisions made here: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/10ps
module pwb_pwm #(
  parameter int unsigned CNT_W = pwb_pkg::CNT_W
) (
  input  wire logic                        clk,
  input  wire logic                        rst,
  input  wire logic [pwb_pkg::ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  output logic [1:0]                       s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  input  wire logic [pwb_pkg::ADDR_W-1:0]  s_axi_araddr,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  output logic [31:0]                      s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  output logic                             pwm_out,
  output logic                             irq
);
  localparam int unsigned AW = pwb_pkg::ADDR_W;

  logic              wr_en;
  logic [AW-1:0]     wr_addr;
  logic [31:0]       wr_data;
  logic [3:0]        wr_strb;
  logic              wr_err;
  logic              rd_en;
  logic [AW-1:0]     rd_addr;
  logic [31:0]       rd_data;
  logic              rd_err;

  pwb_pkg::pwb_ctrl_s ctrl_reg;
  logic [CNT_W-1:0]  period_hold_reg;
  logic [CNT_W-1:0]  pulse_width_hold_reg;
  logic [CNT_W-1:0]  period_active_buffer_reg;
  logic [CNT_W-1:0]  pulse_width_active_buffer_reg;
  logic [CNT_W-1:0]  pwm_count_reg;
  logic              out_ff_reg;
  logic              status_reg;
  logic              irq_en_reg;
  logic              en_d_reg;
  logic              tick;
  logic              load_cmd;
  logic              wr_ctrl;
  logic              wr_period;
  logic              wr_width;
  logic              wr_clear;
  logic              period_end;
  logic              width_hit;
  logic              start_evt;
  logic              period_evt;

  pwb_axil_slave #(
    .AW(AW)
  ) u_bus (
    .clk           (clk),
    .rst           (rst),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .wr_en         (wr_en),
    .wr_addr       (wr_addr),
    .wr_data       (wr_data),
    .wr_strb       (wr_strb),
    .wr_err        (wr_err),
    .rd_en         (rd_en),
    .rd_addr       (rd_addr),
    .rd_data       (rd_data),
    .rd_err        (rd_err)
  );

  pwb_prescaler u_presc (
    .clk      (clk),
    .rst      (rst),
    .hold     (!ctrl_reg.enable || load_cmd),
    .div3     (ctrl_reg.prescale_divide_by_three),
    .rate_sel (ctrl_reg.rate_sel),
    .tick     (tick)
  );

  // write decode
  always_comb begin
    wr_ctrl   = 1'b0;
    wr_period = 1'b0;
    wr_width  = 1'b0;
    wr_clear  = 1'b0;
    wr_err    = 1'b0;
    if (wr_addr == pwb_pkg::OFF_CTRL) begin
      wr_ctrl = wr_en;
    end else if (wr_addr == pwb_pkg::OFF_PERIOD) begin
      wr_period = wr_en;
    end else if (wr_addr == pwb_pkg::OFF_WIDTH) begin
      wr_width = wr_en;
    end else if (wr_addr == pwb_pkg::OFF_IRQ_CLEAR) begin
      wr_clear = wr_en;
    end else if (wr_addr == pwb_pkg::OFF_COUNT || wr_addr == pwb_pkg::OFF_IRQ_ENABLE
                 || wr_addr == pwb_pkg::OFF_IRQ_STATUS) begin
      wr_err = 1'b0; // count and status writes ignored
    end else begin
      wr_err = 1'b1;
    end
  end

  // load acts only when enabled before and after the write
  assign load_cmd   = wr_ctrl && wr_strb[0] && wr_data[pwb_pkg::BIT_LOAD]
                      && ctrl_reg.enable && wr_data[pwb_pkg::BIT_EN];
  assign period_end = ctrl_reg.enable && tick
                      && (pwm_count_reg == period_active_buffer_reg);
  assign width_hit  = ctrl_reg.enable && tick
                      && (pwm_count_reg == pulse_width_active_buffer_reg);
  assign start_evt  = ctrl_reg.enable && !en_d_reg;
  assign period_evt = period_end || load_cmd || start_evt;

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_reg <= '0;
      en_d_reg <= 1'b0;
    end else begin
      en_d_reg <= ctrl_reg.enable;
      if (wr_ctrl && wr_strb[0]) begin
        ctrl_reg.rate_sel                 <= wr_data[pwb_pkg::BIT_CLK_LO +: 3];
        ctrl_reg.enable                   <= wr_data[pwb_pkg::BIT_EN];
        ctrl_reg.output_polarity          <= wr_data[pwb_pkg::BIT_POL];
        ctrl_reg.prescale_divide_by_three <= wr_data[pwb_pkg::BIT_DIV3];
      end
    end
  end

  // holding registers change only on software writes
  always_ff @(posedge clk) begin
    if (rst) begin
      period_hold_reg      <= pwb_pkg::HOLD_RESET;
      pulse_width_hold_reg <= pwb_pkg::HOLD_RESET;
    end else begin
      if (wr_period && (&wr_strb[1:0])) begin
        period_hold_reg <= wr_data[CNT_W-1:0];
      end
      if (wr_width && (&wr_strb[1:0])) begin
        pulse_width_hold_reg <= wr_data[CNT_W-1:0];
      end
    end
  end

  // active buffers, internal only
  always_ff @(posedge clk) begin
    if (rst) begin
      period_active_buffer_reg      <= pwb_pkg::HOLD_RESET;
      pulse_width_active_buffer_reg <= pwb_pkg::HOLD_RESET;
    end else if (!ctrl_reg.enable || period_end || load_cmd) begin
      period_active_buffer_reg      <= period_hold_reg;
      pulse_width_active_buffer_reg <= pulse_width_hold_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pwm_count_reg <= pwb_pkg::COUNT_RESET;
    end else if (!ctrl_reg.enable || load_cmd || period_end) begin
      pwm_count_reg <= pwb_pkg::COUNT_RESET;
    end else if (tick) begin
      pwm_count_reg <= pwm_count_reg + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  // output flip-flop
  always_ff @(posedge clk) begin
    if (rst || !ctrl_reg.enable) begin
      out_ff_reg <= 1'b0;
    end else if (load_cmd) begin
      out_ff_reg <= (pulse_width_hold_reg != '0);
    end else if (start_evt) begin
      out_ff_reg <= (pulse_width_active_buffer_reg != '0);
    end else if (period_end) begin
      out_ff_reg <= (pulse_width_hold_reg != '0);
    end else if (width_hit) begin
      out_ff_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pwm_out <= 1'b0;
    end else begin
      pwm_out <= (ctrl_reg.enable ? out_ff_reg : 1'b0) ^ ctrl_reg.output_polarity;
    end
  end

  // sticky status, set wins over clear
  always_ff @(posedge clk) begin
    if (rst) begin
      status_reg <= 1'b0;
      irq_en_reg <= 1'b0;
      irq        <= 1'b0;
    end else begin
      if (period_evt) begin
        status_reg <= 1'b1;
      end else if (wr_clear && wr_strb[0] && wr_data[pwb_pkg::BIT_IRQ_PERIOD]) begin
        status_reg <= 1'b0;
      end
      if (wr_en && wr_addr == pwb_pkg::OFF_IRQ_ENABLE && wr_strb[0]) begin
        irq_en_reg <= wr_data[pwb_pkg::BIT_IRQ_PERIOD];
      end
      irq <= status_reg && irq_en_reg;
    end
  end

  // read decode
  always_comb begin
    rd_data = '0;
    rd_err  = 1'b0;
    if (rd_addr == pwb_pkg::OFF_CTRL) begin
      rd_data[pwb_pkg::BIT_CLK_LO +: 3] = ctrl_reg.rate_sel;
      rd_data[pwb_pkg::BIT_EN]          = ctrl_reg.enable;
      rd_data[pwb_pkg::BIT_POL]         = ctrl_reg.output_polarity;
      rd_data[pwb_pkg::BIT_DIV3]        = ctrl_reg.prescale_divide_by_three;
      rd_data[pwb_pkg::BIT_PIN]         = pwm_out;
    end else if (rd_addr == pwb_pkg::OFF_PERIOD) begin
      rd_data[CNT_W-1:0] = period_hold_reg;
    end else if (rd_addr == pwb_pkg::OFF_WIDTH) begin
      rd_data[CNT_W-1:0] = pulse_width_hold_reg;
    end else if (rd_addr == pwb_pkg::OFF_COUNT) begin
      rd_data[CNT_W-1:0] = pwm_count_reg;
    end else if (rd_addr == pwb_pkg::OFF_IRQ_STATUS) begin
      rd_data[pwb_pkg::BIT_IRQ_PERIOD] = status_reg;
    end else if (rd_addr == pwb_pkg::OFF_IRQ_ENABLE) begin
      rd_data[pwb_pkg::BIT_IRQ_PERIOD] = irq_en_reg;
    end else if (rd_addr == pwb_pkg::OFF_IRQ_CLEAR) begin
      rd_data = '0;
    end else begin
      rd_err = 1'b1;
    end
  end
endmodule

// ---- test/pwb_pwm_sva.sv ----
// Purpose: port checker for pwb_pwm
// Assumes: aw and w offered together, bready held high
// Notes:   shadows enable, polarity and irq enable from bus writes
`timescale 1ns/10ps
module pwb_pwm_sva #(
  parameter int unsigned CNT_W = 16
) (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        pwm_out,
  input wire logic        irq
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  logic       wr_take;
  logic       en_sh;
  logic       pol_sh;
  logic       ie_sh;
  logic [3:0] dis_cnt;
  assign wr_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  always_ff @(posedge clk) begin
    if (rst) begin
      en_sh   <= 1'b0;
      pol_sh  <= 1'b0;
      dis_cnt <= 4'h0;
    end else if (wr_take && s_axi_awaddr == pwb_pkg::OFF_CTRL) begin
      en_sh   <= s_axi_wdata[pwb_pkg::BIT_EN];
      pol_sh  <= s_axi_wdata[pwb_pkg::BIT_POL];
      dis_cnt <= 4'h0;
    end else if (!en_sh && dis_cnt != 4'hF) begin
      dis_cnt <= dis_cnt + 4'h1;
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      ie_sh <= 1'b0;
    end else if (wr_take && s_axi_awaddr == pwb_pkg::OFF_IRQ_ENABLE) begin
      ie_sh <= s_axi_wdata[0];
    end
  end
  sequence s_wr_take;
    wr_take;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_enable_rise;
    wr_take && s_axi_awaddr == pwb_pkg::OFF_CTRL && s_axi_wdata[pwb_pkg::BIT_EN] && !en_sh;
  endsequence
  a_wr_answer: assert property (s_wr_take |-> ##[1:2] s_axi_bvalid)
    else $error("write not answered");
  a_wr_unmapped: assert property (wr_take && s_axi_awaddr > pwb_pkg::OFF_IRQ_CLEAR
    |-> ##[1:2] (s_axi_bvalid && s_axi_bresp == pwb_pkg::RESP_SLVERR))
    else $error("unmapped write not refused");
  a_one_answer: assert property (s_axi_bvalid |=> !s_axi_bvalid && s_axi_awready)
    else $error("write answer not closed");
  a_rd_answer: assert property (s_rd_take |-> ##[1:2] s_axi_rvalid)
    else $error("read not answered");
  a_count_idle: assert property (s_axi_arvalid && s_axi_arready
    && s_axi_araddr == pwb_pkg::OFF_COUNT && dis_cnt >= 4'h4
    |-> ##1 (s_axi_rvalid && s_axi_rdata[15:0] == pwb_pkg::COUNT_RESET))
    else $error("count not one while disabled");
  a_idle_level: assert property (dis_cnt >= 4'h4 |-> pwm_out == pol_sh)
    else $error("idle pin level wrong");
  a_irq_masked: assert property (!ie_sh && !$past(ie_sh) && !$past(ie_sh, 2)
    && !$past(ie_sh, 3) |-> !irq)
    else $error("masked interrupt raised");
  a_enable_flag: assert property (s_enable_rise ##0 ie_sh |-> ##[1:5] irq)
    else $error("no flag on enable");
endmodule

// ---- test/pwb_pwm_tb_top.sv ----
// Purpose: self-checking bench for pwb_pwm
// Assumes: bready and rready held high, full strobes
// Notes:   pulse timing expected from the rate table and count rules
`timescale 1ns/10ps
module pwb_pwm_tb_top;
  logic        clk;
  logic        rst;
  logic [7:0]  s_axi_awaddr;
  logic        s_axi_awvalid;
  logic        s_axi_awready;
  logic [31:0] s_axi_wdata;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_wvalid;
  logic        s_axi_wready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_bvalid;
  logic        s_axi_bready;
  logic [7:0]  s_axi_araddr;
  logic        s_axi_arvalid;
  logic        s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_rvalid;
  logic        s_axi_rready;
  logic        pwm_out;
  logic        irq;
  logic [31:0] rd_data;
  logic [1:0]  rd_resp;
  logic [1:0]  wr_resp;
  int          bad_count;
  int          comparisons;
  int          cyc;
  int          t_rise;
  localparam logic [31:0] EN  = 32'h1 << pwb_pkg::BIT_EN;
  localparam logic [31:0] OUTPUT_POLARITY = 32'h1 << pwb_pkg::BIT_POL;
  localparam logic [31:0] LD  = 32'h1 << pwb_pkg::BIT_LOAD;
  localparam logic [31:0] D3  = 32'h1 << pwb_pkg::BIT_DIV3;
  localparam logic [31:0] PIN = 32'h1 << pwb_pkg::BIT_PIN;
  pwb_pwm #(.CNT_W(16)) u_pwb_pwm (
    .clk(clk), .rst(rst), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .pwm_out(pwm_out), .irq(irq));
  always #4 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    $display("comparisons=%0d mismatches=%0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic wcyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bit dn;
    dn = 0;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    while (!dn) begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        wr_resp = s_axi_bresp;
        dn = 1;
      end
    end
  endtask
  task automatic rd(input logic [7:0] a);
    bit dn;
    dn = 0;
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    while (!dn) begin
      @(posedge clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        rd_data = s_axi_rdata;
        rd_resp = s_axi_rresp;
        dn = 1;
      end
    end
  endtask
  // measures one full period from the next active edge
  task automatic meas(input logic act, input int hi, input int per);
    int n;
    n = 0;
    while (pwm_out === act) @(posedge clk);
    while (pwm_out !== act) @(posedge clk);
    while (pwm_out === act) begin
      @(posedge clk);
      n++;
    end
    chk(n, hi);
    while (pwm_out !== act) begin
      @(posedge clk);
      n++;
    end
    chk(n, per);
    t_rise = cyc;
  endtask
  task automatic t_regs;
    logic [7:0] ofs [6];
    ofs = '{pwb_pkg::OFF_CTRL, pwb_pkg::OFF_PERIOD, pwb_pkg::OFF_WIDTH, pwb_pkg::OFF_COUNT,
            pwb_pkg::OFF_IRQ_STATUS, pwb_pkg::OFF_IRQ_ENABLE};
    foreach (ofs[i]) begin
      rd(ofs[i]);
      chk(rd_data, (ofs[i] == pwb_pkg::OFF_COUNT) ? 32'h1 : 32'h0);
    end
    chk(pwm_out, 1'b0);
    wr(pwb_pkg::OFF_PERIOD, 32'h1234);
    wr(pwb_pkg::OFF_WIDTH, 32'hABCD);
    wr(pwb_pkg::OFF_COUNT, 32'h55);
    chk(wr_resp, pwb_pkg::RESP_OKAY);
    rd(pwb_pkg::OFF_COUNT);
    chk(rd_data, 32'h1);
    rd(pwb_pkg::OFF_WIDTH);
    chk(rd_data, 32'hABCD);
    wr(8'h1C, 32'hFFFF);
    chk(wr_resp, pwb_pkg::RESP_SLVERR);
    rd(8'h1C);
    chk(rd_resp, pwb_pkg::RESP_SLVERR);
    $display("test regs done");
  endtask
  task automatic t_rates;
    int dv;
    wr(pwb_pkg::OFF_PERIOD, 32'h3);
    wr(pwb_pkg::OFF_WIDTH, 32'h1);
    for (int d = 0; d < 2; d++) begin
      for (int c = 0; c < 8; c++) begin
        dv = (c == 7) ? 512 : (2 << c);
        if (d == 1) dv = dv * 3 / 2;
        wr(pwb_pkg::OFF_CTRL, 32'h0);
        wr(pwb_pkg::OFF_CTRL, EN | (d == 1 ? D3 : 32'h0) | 32'(c));
        wcyc(4);
        meas(1'b1, dv, 3 * dv);
      end
    end
    rd(pwb_pkg::OFF_PERIOD);
    chk(rd_data, 32'h3);
    $display("test rates done");
  endtask
  task automatic t_update;
    wr(pwb_pkg::OFF_CTRL, 32'h0);
    wr(pwb_pkg::OFF_PERIOD, 32'h4);
    wr(pwb_pkg::OFF_CTRL, EN | 32'h3);
    wcyc(4);
    meas(1'b1, 16, 64);
    wr(pwb_pkg::OFF_WIDTH, 32'h3);
    while (pwm_out === 1'b1) @(posedge clk);
    chk(cyc - t_rise, 16);
    meas(1'b1, 48, 64);
    wr(pwb_pkg::OFF_WIDTH, 32'h1);
    wr(pwb_pkg::OFF_IRQ_CLEAR, 32'h1);
    while (pwm_out === 1'b1) @(posedge clk);
    wr(pwb_pkg::OFF_CTRL, EN | LD | 32'h3);
    wcyc(3);
    chk(pwm_out, 1'b1);
    rd(pwb_pkg::OFF_IRQ_STATUS);
    chk(rd_data, 32'h1);
    $display("test update done");
  endtask
  task automatic t_zero_pol;
    wr(pwb_pkg::OFF_CTRL, 32'h0);
    wr(pwb_pkg::OFF_PERIOD, 32'h3);
    wr(pwb_pkg::OFF_WIDTH, 32'h0);
    wr(pwb_pkg::OFF_CTRL, EN);
    repeat (20) begin
      @(posedge clk);
      chk(pwm_out, 1'b0);
    end
    rd(pwb_pkg::OFF_COUNT);
    chk(rd_data >= 32'h1 && rd_data <= 32'h3, 1'b1);
    wr(pwb_pkg::OFF_CTRL, OUTPUT_POLARITY);
    wcyc(4);
    chk(pwm_out, 1'b1);
    rd(pwb_pkg::OFF_CTRL);
    chk(rd_data, OUTPUT_POLARITY | PIN);
    wr(pwb_pkg::OFF_WIDTH, 32'h1);
    wr(pwb_pkg::OFF_CTRL, OUTPUT_POLARITY | EN);
    wcyc(4);
    meas(1'b0, 2, 6);
    $display("test zero and polarity done");
  endtask
  task automatic t_irq;
    wr(pwb_pkg::OFF_CTRL, 32'h0);
    wr(pwb_pkg::OFF_IRQ_CLEAR, 32'h1);
    wr(pwb_pkg::OFF_IRQ_ENABLE, 32'h1);
    wcyc(3);
    chk(irq, 1'b0);
    wr(pwb_pkg::OFF_CTRL, EN | 32'h7);
    wcyc(4);
    chk(irq, 1'b1);
    wr(pwb_pkg::OFF_IRQ_ENABLE, 32'h0);
    wcyc(3);
    chk(irq, 1'b0);
    wr(pwb_pkg::OFF_CTRL, EN);
    wr(pwb_pkg::OFF_IRQ_CLEAR, 32'h1);
    wcyc(8);
    rd(pwb_pkg::OFF_IRQ_STATUS);
    chk(rd_data, 32'h1);
    wr(pwb_pkg::OFF_CTRL, 32'h0);
    wr(pwb_pkg::OFF_IRQ_CLEAR, 32'h1);
    rd(pwb_pkg::OFF_IRQ_STATUS);
    chk(rd_data, 32'h0);
    $display("test irq done");
  endtask
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    cyc = 0;
    bad_count = 0;
    comparisons = 0;
    s_axi_awaddr = 8'h00;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b1;
    s_axi_araddr = 8'h00;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_rates();
    t_update();
    t_zero_pol();
    t_irq();
    end_sim();
  end
  initial begin
    repeat (60000) @(posedge clk);
    bad_count++;
    end_sim();
  end
endmodule
bind pwb_pwm pwb_pwm_sva #(.CNT_W(CNT_W)) u_pwb_pwm_sva (
  .clk(clk), .rst(rst), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .pwm_out(pwm_out), .irq(irq));
